// >>> hw/fomc_top.sv
// output-mode control register and its decode into converter control
// assumes a byte register port from the host interface, one access per strobe
// the flash timer length is a parameter so that simulation can shorten it
`timescale 1ns/100ps
`default_nettype none
module fomc_top
#(
   parameter int flash_cycles = fomc_pkg::fomc_flash_cycles
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // host register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // trigger pin and polarity setting from the input control register
   input wire logic trigger_pin,
   input wire logic trigger_polarity_sel,
   // converter and current source control
   output fomc_pkg::fomc_drive_t drive,
   output logic flash_active
);
   // one-hot flash sequencer
   typedef enum logic [2:0]
   {
      fl_idle = 3'h1,
      fl_on = 3'h2,
      fl_done = 3'h4
   } fomc_fl_t;

   // all state of the block except the trigger qualifier's, registered as one copy
   typedef struct packed {
      fomc_pkg::fomc_ctrl_t ctrl;
      logic [7:0] rdata;
      fomc_fl_t fl;
      logic [31:0] timer;
      fomc_pkg::fomc_drive_t drive;
   } fomc_state_t;

   fomc_state_t state;
   fomc_state_t next_state;
   logic trig_active;
   logic trig_rise;
   logic hit;
   // decode of the value live after this edge
   logic write_hit;
   fomc_pkg::fomc_ctrl_t next_ctrl;
   logic rail_mode;
   logic assist_mode;
   logic flash_mode;
   // flash start and stop conditions
   logic hw_source;
   logic level_sense;
   logic soft_start;
   logic level_start;
   logic edge_start;
   logic level_drop;
   logic timer_end;
   // drive value loaded by reset
   fomc_pkg::fomc_drive_t reset_drive;

   fomc_trigger u_trigger
   (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .trigger_pin(trigger_pin),
      .trigger_polarity_sel(trigger_polarity_sel),
      .active(trig_active),
      .rise(trig_rise)
   );

   // the request is taken only at the one mapped offset
   assign hit = (reg_addr == fomc_pkg::fomc_reg_addr);
   assign write_hit = reg_wr && hit;

   // value live after this edge; the decode sees a write at once, which
   // is what lets the outputs change on the same edge that takes the write
   assign next_ctrl = write_hit ? fomc_pkg::fomc_ctrl_t'(reg_wdata) : state.ctrl;

   // output gating of the rail, assist and flash lamp modes
   assign rail_mode = next_ctrl.output_on
      && (next_ctrl.lamp_mode_sel == fomc_pkg::fomc_mode_voltage);
   assign assist_mode = next_ctrl.output_on
      && (next_ctrl.lamp_mode_sel == fomc_pkg::fomc_mode_assist);
   assign flash_mode = next_ctrl.output_on
      && (next_ctrl.lamp_mode_sel == fomc_pkg::fomc_mode_flash);

   // trigger source and sensitivity as set by the host
   assign hw_source = next_ctrl.trigger_source_sel;
   assign level_sense = next_ctrl.trigger_sensitivity_sel;

   assign soft_start = flash_mode && !hw_source;

   // hardware level start needs the pin active
   assign level_start = flash_mode && hw_source && level_sense && trig_active;

   // hardware edge start on the active edge only
   assign edge_start = flash_mode && hw_source && !level_sense && trig_rise;

   // a level flash drops with the pin
   assign level_drop = hw_source && level_sense && !trig_active;

   // checked on the held count, so a flash lasts exactly flash_cycles clocks
   assign timer_end = (state.timer >= 32'(flash_cycles - 1));

   // reset image of the drive: only the peak limit is nonzero
   assign reset_drive = {
      fomc_pkg::fomc_reg_reset[fomc_pkg::fomc_peak_msb:fomc_pkg::fomc_peak_lsb],
      5'h00
   };

   always_comb
   begin
      next_state = state;

      // register write lands in the held copy
      next_state.ctrl = next_ctrl;

      // read back the held value, zero off the map; a write in the
      // same cycle is not yet visible to the read
      if (reg_rd)
      begin
         if (hit)
            next_state.rdata = 8'(state.ctrl);
         else
            next_state.rdata = 8'h00;
      end

      case (state.fl)
         fl_idle:
         begin
            next_state.timer = 32'h0;
            // any armed source starts the flash
            if (soft_start || level_start || edge_start)
               next_state.fl = fl_on;
         end

         fl_on:
         begin
            next_state.timer = state.timer + 32'h1;
            // leaving flash mode or turning the output off cuts the flash at once
            // level ends with trigger, otherwise the timer ends it
            if (!flash_mode || level_drop)
               next_state.fl = fl_idle;
            else if (timer_end)
               next_state.fl = fl_done;
         end

         fl_done:
         begin
            // one flash per enable; rearm on leaving flash mode or pin release
            // a pin held in edge mode gives one flash; it must drop first
            if (!flash_mode || (hw_source && !trig_active))
               next_state.fl = fl_idle;
         end

         default:
         begin
            next_state.timer = 32'h0;
            next_state.fl = fl_idle;
         end
      endcase

      // outputs follow the new value on the same edge that takes the write
      next_state.drive.inductor_peak_limit_sel = next_ctrl.inductor_peak_limit_sel;
      next_state.drive.switch_freq_foldback_permit = next_ctrl.switch_freq_foldback_permit;
      // mode decode; one load at most
      next_state.drive.boosted_rail_voltage = 1'b0;
      next_state.drive.assist_current_on = 1'b0;
      next_state.drive.flash_current_on = 1'b0;
      // fixed 5 V rail, led current stays off
      if (rail_mode)
         next_state.drive.boosted_rail_voltage = 1'b1;
      else if (assist_mode)
         next_state.drive.assist_current_on = 1'b1;
      else if (flash_mode && (next_state.fl == fl_on))
         next_state.drive.flash_current_on = 1'b1;
      // boost runs whenever any of the three loads is on
      next_state.drive.boost_enable = next_state.drive.boosted_rail_voltage
         || next_state.drive.assist_current_on || next_state.drive.flash_current_on;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         // register defaults; the drive shows only the peak limit
         state.ctrl <= fomc_pkg::fomc_reg_reset;
         state.rdata <= 8'h00;
         state.fl <= fl_idle;
         state.timer <= 32'h0;
         state.drive <= reset_drive;
      end
      else
         state <= next_state;
   end

   // all outputs straight from flip-flops

   assign reg_rdata = state.rdata;
   assign drive = state.drive;
   assign flash_active = state.drive.flash_current_on;
endmodule // fomc_top
`default_nettype wire

// >>> common/fomc_pkg.sv
// constants and carrier types for the flash output-mode control block
// assumes a host register port that delivers byte writes and reads
package fomc_pkg;
   localparam logic [7:0] fomc_reg_addr = 8'h04;
   localparam logic [7:0] fomc_reg_reset = 8'ha4;
   localparam int fomc_peak_msb = 7;
   localparam int fomc_peak_lsb = 6;
   localparam int fomc_sens_bit = 5;
   localparam int fomc_fold_bit = 4;
   localparam int fomc_out_bit = 3;
   localparam int fomc_src_bit = 2;
   localparam int fomc_mode_msb = 1;
   localparam int fomc_mode_lsb = 0;
   localparam logic [1:0] fomc_mode_standby = 2'h0;
   localparam logic [1:0] fomc_mode_voltage = 2'h1;
   localparam logic [1:0] fomc_mode_assist = 2'h2;
   localparam logic [1:0] fomc_mode_flash = 2'h3;
   // flash timer: 1600 ms default at 50 MHz
   localparam int fomc_clk_mhz = 50;
   localparam int fomc_flash_ms = 1600;
   localparam int fomc_flash_cycles = fomc_flash_ms * 1000 * fomc_clk_mhz;

   typedef struct packed {
      logic [1:0] inductor_peak_limit_sel;
      logic trigger_sensitivity_sel;
      logic switch_freq_foldback_permit;
      logic output_on;
      logic trigger_source_sel;
      logic [1:0] lamp_mode_sel;
   } fomc_ctrl_t;

   typedef struct packed {
      logic [1:0] inductor_peak_limit_sel;
      logic switch_freq_foldback_permit;
      logic boost_enable;
      logic boosted_rail_voltage;
      logic assist_current_on;
      logic flash_current_on;
   } fomc_drive_t;
endpackage

// >>> hw/fomc_trigger.sv
// trigger pin qualifier: polarity and edge detect
// assumes the trigger pin is already synchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module fomc_trigger
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // pin and setting
   input wire logic trigger_pin,
   input wire logic trigger_polarity_sel,
   // qualified trigger
   output logic active,
   output logic rise
);
   typedef struct packed {
      logic last;
   } fomc_trig_state_t;

   fomc_trig_state_t state;
   fomc_trig_state_t next_state;

   assign active = trigger_polarity_sel ? trigger_pin : ~trigger_pin;
   assign rise = active & ~state.last;

   always_comb
   begin
      next_state = state;
      next_state.last = active;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         state <= '0;
      else
         state <= next_state;
   end
endmodule // fomc_trigger
`default_nettype wire

// >>> test/fomc_checker.sv
// port assertions for the output-mode control block
// assumes one clock domain, bound into fomc_top
`timescale 1ns/100ps
`default_nettype none
module fomc_checker
#(
   parameter int flash_cycles = fomc_pkg::fomc_flash_cycles
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // host port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // drive
   input wire fomc_pkg::fomc_drive_t drive,
   input wire logic flash_active
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire logic hit = reg_wr && reg_addr == fomc_pkg::fomc_reg_addr;
   wire logic on = hit && reg_wdata[3];
   // length of the current unbroken flash, saturating
   logic [31:0] run;
   always_ff @(posedge sys_clk)
   begin
      if (!rstn || !flash_active)
         run <= 32'h0;
      else if (run != 32'hffffffff)
         run <= run + 32'h1;
   end
   a_peak_follows: assert property (hit |=> drive[6:5] == $past(reg_wdata[7:6]))
      else $error("peak limit not taken");
   a_fold_follows: assert property (hit |=> drive[4] == $past(reg_wdata[4]))
      else $error("foldback permit not taken");
   a_output_off: assert property (hit && !reg_wdata[3] |=> drive[3:0] == 4'h0)
      else $error("output on while off");
   a_unmapped_read: assert property (reg_rd && reg_addr != 8'h04 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rail_mode: assert property (on && reg_wdata[1:0] == 2'h1 |=> drive[3:2] == 2'h3)
      else $error("fixed rail not set");
   a_rail_dark: assert property (drive[2] |-> drive[1:0] == 2'h0)
      else $error("led current in rail mode");
   a_soft_flash: assert property (on && reg_wdata[2:0] == 3'h3 |=> flash_active)
      else $error("software flash missing");
   a_standby_dark: assert property (hit && reg_wdata[1:0] == 2'h0 |=> drive[2:0] == 3'h0)
      else $error("standby not dark");
   a_flash_bounded: assert property (run <= 32'(flash_cycles))
      else $error("flash outlived its timer");
   cover property (on && reg_wdata[1:0] == 2'h3);
   cover property ($rose(flash_active));
   cover property (reg_rd && reg_addr != 8'h04);
endmodule // fomc_checker
bind fomc_top fomc_checker #(.flash_cycles(flash_cycles)) chk (.sys_clk(sys_clk), .rstn(rstn),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .drive(drive), .flash_active(flash_active));
`default_nettype wire

// >>> test/fomc_host.sv
// host and trigger controller model facing the block
// assumes inputs change at the falling edge of sys_clk
`timescale 1ns/100ps
`default_nettype none
module fomc_host
(
   // clock
   input wire logic sys_clk,
   // register port
   output logic [7:0] reg_addr = 8'h00,
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [7:0] reg_wdata = 8'h00,
   input wire logic [7:0] reg_rdata,
   // trigger pin
   output logic trigger_pin = 1'b0
);
   // released lines flip so a stale value is never seen
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge sys_clk);
      {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge sys_clk);
      {reg_addr, reg_rd} = {~a, 1'b0};
      d = reg_rdata;
   endtask
   task automatic trig(input logic v);
      @(negedge sys_clk);
      trigger_pin = v;
   endtask
endmodule // fomc_host
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the output-mode control block
// assumes fomc_host as the host and a short flash timer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic trigger_polarity_sel = 1'b1;
   wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
   wire logic reg_wr, reg_rd, trigger_pin, flash_active;
   fomc_pkg::fomc_drive_t drive;
   localparam int sim_flash = 20;
   logic [7:0] v;
   logic [7:0] e;
   int fails = 0;
   int total_checks = 0;
   fomc_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .trigger_pin(trigger_pin));
   fomc_top #(.flash_cycles(sim_flash)) dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .trigger_pin(trigger_pin), .trigger_polarity_sel(trigger_polarity_sel),
      .drive(drive), .flash_active(flash_active));
   initial
   begin
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("fails=%0d total_checks=%0d", fails, total_checks);
      if (fails == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_modes();
      for (int m = 0; m < 4; m++)
      begin
         host.wr(8'h04, 8'hd8 | 8'(m));
         e = 8'h70 | 8'(m != 0) << 3 | 8'(m == 1) << 2 | 8'(m == 2) << 1 | 8'(m == 3);
         chk({1'b0, drive}, e);
         host.rd(8'h04, v);
         chk(v, 8'hd8 | 8'(m));
      end
      host.wr(8'h05, 8'hff);
      host.rd(8'h05, v);
      chk(v, 8'h00);
      host.rd(8'h04, v);
      chk(v, 8'hdb);
   endtask
   task automatic t_level();
      host.wr(8'h04, 8'h08);
      host.wr(8'h04, 8'h2f);
      repeat (3) @(negedge sys_clk);
      chk(8'(flash_active), 8'h00);
      host.trig(1'b1);
      repeat (3) @(negedge sys_clk);
      chk(8'(flash_active), 8'h01);
      host.trig(1'b0);
      repeat (3) @(negedge sys_clk);
      chk(8'(flash_active), 8'h00);
      trigger_polarity_sel = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk(8'(flash_active), 8'h01);
      trigger_polarity_sel = 1'b1;
   endtask
   task automatic t_edge();
      logic [7:0] n;
      n = 8'h00;
      host.wr(8'h04, 8'h08);
      host.wr(8'h04, 8'h0f);
      host.trig(1'b1);
      // pin stays high: only the timer may end the flash
      repeat (40) @(negedge sys_clk) n += 8'(flash_active === 1'b1);
      chk(n, 8'(sim_flash));
      host.trig(1'b0);
   endtask
   task automatic t_reset();
      // software flash running when reset falls mid-run
      host.wr(8'h04, 8'h5b);
      chk(8'(flash_active), 8'h01);
      @(negedge sys_clk) rstn = 1'b0;
      repeat (2) @(negedge sys_clk);
      rstn = 1'b1;
      chk(8'(flash_active), 8'h00);
      chk({1'b0, drive}, 8'h40);
      host.rd(8'h04, v);
      chk(v, fomc_pkg::fomc_reg_reset);
   endtask
   initial
   begin
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk) rstn = 1'b1;
      host.rd(8'h04, v);
      chk(v, fomc_pkg::fomc_reg_reset);
      chk({1'b0, drive}, 8'h40);
      t_modes();
      t_level();
      t_edge();
      t_reset();
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
